// File: verilog/epr_regs.svh
`ifndef EPR_REGS_SVH
`define EPR_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EPR_OFS_CTRL      8'h00
`define EPR_OFS_RES       8'h04
`define EPR_OFS_PRESET    8'h08
`define EPR_OFS_LIM_MIN   8'h0C
`define EPR_OFS_LIM_MAX   8'h10
`define EPR_OFS_CYCLE     8'h14
`define EPR_OFS_SYNC_N    8'h18
`define EPR_OFS_NODE_ID   8'h1C
`define EPR_OFS_POS       8'h20
`define EPR_OFS_CAM_STAT  8'h24
`define EPR_OFS_IRQ_STAT  8'h28
`define EPR_OFS_IRQ_MASK  8'h2C
`define EPR_CAM_PAGE      2'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EPR_CTRL_DIR_BIT  0
`define EPR_CTRL_MODE_LSB 1
`define EPR_MODE_CYCLIC   2'h1
`define EPR_MODE_SYNC     2'h2
`define EPR_LIMIT_BIT     31
`define EPR_IRQ_TX_BIT    0
`define EPR_IRQ_LIM_BIT   1
`define EPR_IRQ_CAM_BIT   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPR_RES_RESET     32'h00010000
`define EPR_LIM_MAX_RESET 32'h7FFFFFFF
`define EPR_CYCLE_RESET   16'h0063
`define EPR_SYNC_N_RESET  16'h0001
`define EPR_NODE_ID_RESET 11'h181

// ----------------------------------------
// Timing
// ----------------------------------------
`define EPR_TICK_MS       1
`define EPR_CLK_KHZ       50000
`define EPR_TICK_CYCLES   (`EPR_TICK_MS * `EPR_CLK_KHZ)
`define EPR_PIPE_CYCLES   2'h2

`endif

// File: verilog/epr_pkg.sv
package epr_pkg;

    typedef enum logic [1:0] {
        EPR_POLLED,
        EPR_CYCLIC,
        EPR_SYNC
    } epr_mode_t;

    typedef enum logic [1:0] {
        EPR_IDLE,
        EPR_WAIT,
        EPR_LOAD,
        EPR_SEND
    } epr_state_t;

    // Resolution scaling: raw counts times steps, divided by raw steps per turn
    function automatic logic [31:0] epr_scale(input logic [31:0] raw,
                                              input logic [31:0] steps,
                                              input int         st_bits);
        logic [63:0] prod;
        prod = {32'h00000000, raw} * {32'h00000000, steps};
        return 32'((prod >> st_bits) & 64'h00000000FFFFFFFF);
    endfunction

    function automatic logic epr_in_window(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

endpackage

// File: verilog/epr_if.sv
interface epr_if #(
    parameter int W    = 32,
    parameter int CAMS = 8
);
    logic [W-1:0]    raw_pos;
    logic [W-1:0]    res;
    logic [W-1:0]    offset;
    logic            dir;
    logic [W-1:0]    p_dir;
    logic [W-1:0]    pos;
    logic [W-1:0]    cam_lo [CAMS];
    logic [W-1:0]    cam_hi [CAMS];
    logic [CAMS-1:0] cam_hit;

    modport ctl (output raw_pos, res, offset, dir, cam_lo, cam_hi,
                 input  p_dir, pos, cam_hit);
    modport xf  (input  raw_pos, res, offset, dir,
                 output p_dir, pos);
    modport cm  (input  pos, cam_lo, cam_hi,
                 output cam_hit);
endinterface

// File: verilog/epr_xform.sv
module epr_xform #(
    parameter int ST_BITS = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    epr_if.xf        bus
);
    logic [31:0] scaled;

    assign scaled = epr_pkg::epr_scale(bus.raw_pos, bus.res, ST_BITS);

    // Two stages: direction first, then the preset offset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus.p_dir <= 32'h00000000;
            bus.pos   <= 32'h00000000;
        end else begin
            bus.p_dir <= bus.dir ? (32'h00000000 - scaled) : scaled;
            bus.pos   <= bus.p_dir + bus.offset;
        end
    end
endmodule

// File: verilog/epr_cam.sv
module epr_cam #(
    parameter int CAMS = 8
) (
    epr_if.cm bus
);
    always_comb begin
        for (int i = 0; i < CAMS; i++) begin
            bus.cam_hit[i] = epr_pkg::epr_in_window(bus.pos, bus.cam_lo[i],
                                                    bus.cam_hi[i]);
        end
    end
endmodule

// File: verilog/epr_top.sv
`include "epr_regs.svh"

module epr_top #(
    parameter int          ST_BITS     = 16,
    parameter int          CAMS        = 8,
    parameter logic [31:0] TICK_CYCLES = `EPR_TICK_CYCLES
) (
    input  wire logic            clock,
    input  wire logic            rst_b,
    input  wire logic [31:0]     raw_pos,
    input  wire logic            rtr_req,
    input  wire logic [10:0]     rtr_id,
    input  wire logic            sync_pulse,
    input  wire logic            tx_ready,
    output logic                 tx_valid,
    output logic [10:0]          tx_id,
    output logic [31:0]          tx_data,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata,
    output logic [CAMS-1:0]      cam_out,
    output logic                 irq
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic                   dir_reg;
    epr_pkg::epr_mode_t     mode_reg;
    logic [31:0]            res_reg;
    logic [31:0]            offset_reg;
    logic [31:0]            lim_min_reg;
    logic [31:0]            lim_max_reg;
    logic [15:0]            cycle_reg;
    logic [15:0]            sync_n_reg;
    logic [10:0]            node_id_reg;
    logic [31:0]            cam_lo_reg [CAMS];
    logic [31:0]            cam_hi_reg [CAMS];
    logic [2:0]             irq_stat_reg;
    logic [2:0]             irq_stat_next;
    logic [2:0]             irq_mask_reg;
    logic [31:0]            raw_snap_reg;
    logic [31:0]            tick_cnt_reg;
    logic                   tick_reg;
    logic [15:0]            ms_cnt_reg;
    logic [15:0]            sync_cnt_reg;
    logic [1:0]             wait_reg;
    logic                   out_range_reg;
    logic [CAMS-1:0]        cam_prev_reg;
    logic [31:0]            rd_next;
    epr_pkg::epr_state_t    state_reg;
    epr_pkg::epr_state_t    state_next;

    logic                   poll_hit;
    logic                   cyc_fire;
    logic                   sync_fire;
    logic                   trig;
    logic                   out_range;
    logic                   tx_done;
    logic [2:0]             events;
    logic                   cam_sel;
    logic [2:0]             cam_idx;

    epr_if #(.W(32), .CAMS(CAMS)) bus ();

    // ----------------------------------------
    // Position pipeline
    // ----------------------------------------
    assign bus.raw_pos = raw_snap_reg;
    assign bus.res     = res_reg;
    assign bus.offset  = offset_reg;
    assign bus.dir     = dir_reg;
    always_comb begin
        for (int i = 0; i < CAMS; i++) begin
            bus.cam_lo[i] = cam_lo_reg[i];
            bus.cam_hi[i] = cam_hi_reg[i];
        end
    end

    epr_xform #(.ST_BITS(ST_BITS)) u_xform (
        .clock (clock),
        .rst_b (rst_b),
        .bus   (bus.xf)
    );

    epr_cam #(.CAMS(CAMS)) u_cam (
        .bus (bus.cm)
    );

    // Snapshot tracks the shaft while idle and freezes at the trigger
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            raw_snap_reg <= 32'h00000000;
        end else if (state_reg == epr_pkg::EPR_IDLE) begin
            raw_snap_reg <= raw_pos;
        end
    end

    assign out_range = (bus.pos < lim_min_reg) || (bus.pos > lim_max_reg);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    assign cam_sel = (reg_addr[7:6] == `EPR_CAM_PAGE) && (reg_addr[1:0] == 2'h0);
    assign cam_idx = reg_addr[5:3];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dir_reg     <= 1'b0;
            mode_reg    <= epr_pkg::EPR_POLLED;
            res_reg     <= `EPR_RES_RESET;
            offset_reg  <= 32'h00000000;
            lim_min_reg <= 32'h00000000;
            lim_max_reg <= `EPR_LIM_MAX_RESET;
            cycle_reg   <= `EPR_CYCLE_RESET;
            sync_n_reg  <= `EPR_SYNC_N_RESET;
            node_id_reg <= `EPR_NODE_ID_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `EPR_OFS_CTRL: begin
                    dir_reg <= reg_wdata[`EPR_CTRL_DIR_BIT];
                    case (reg_wdata[`EPR_CTRL_MODE_LSB +: 2])
                        `EPR_MODE_CYCLIC: mode_reg <= epr_pkg::EPR_CYCLIC;
                        `EPR_MODE_SYNC:   mode_reg <= epr_pkg::EPR_SYNC;
                        default:          mode_reg <= epr_pkg::EPR_POLLED;
                    endcase
                end
                `EPR_OFS_RES:     res_reg     <= reg_wdata;
                `EPR_OFS_PRESET:  offset_reg  <= reg_wdata - bus.p_dir;
                `EPR_OFS_LIM_MIN: lim_min_reg <= reg_wdata;
                `EPR_OFS_LIM_MAX: lim_max_reg <= reg_wdata;
                `EPR_OFS_CYCLE:   cycle_reg   <= reg_wdata[15:0];
                `EPR_OFS_SYNC_N:  sync_n_reg  <= reg_wdata[15:0];
                `EPR_OFS_NODE_ID: node_id_reg <= reg_wdata[10:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < CAMS; i++) begin
                cam_lo_reg[i] <= 32'h00000000;
                cam_hi_reg[i] <= 32'h00000000;
            end
        end else if (reg_wr && cam_sel) begin
            if (reg_addr[2]) begin
                cam_hi_reg[cam_idx] <= reg_wdata;
            end else begin
                cam_lo_reg[cam_idx] <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb begin
        rd_next = 32'h00000000;
        case (reg_addr)
            `EPR_OFS_CTRL: begin
                rd_next[`EPR_CTRL_DIR_BIT] = dir_reg;
                case (mode_reg)
                    epr_pkg::EPR_CYCLIC: rd_next[`EPR_CTRL_MODE_LSB +: 2] = `EPR_MODE_CYCLIC;
                    epr_pkg::EPR_SYNC:   rd_next[`EPR_CTRL_MODE_LSB +: 2] = `EPR_MODE_SYNC;
                    default:             rd_next[`EPR_CTRL_MODE_LSB +: 2] = 2'h0;
                endcase
            end
            `EPR_OFS_RES:      rd_next = res_reg;
            `EPR_OFS_PRESET:   rd_next = offset_reg;
            `EPR_OFS_LIM_MIN:  rd_next = lim_min_reg;
            `EPR_OFS_LIM_MAX:  rd_next = lim_max_reg;
            `EPR_OFS_CYCLE:    rd_next = {16'h0000, cycle_reg};
            `EPR_OFS_SYNC_N:   rd_next = {16'h0000, sync_n_reg};
            `EPR_OFS_NODE_ID:  rd_next = {21'h000000, node_id_reg};
            `EPR_OFS_POS:      rd_next = {out_range, bus.pos[30:0]};
            `EPR_OFS_CAM_STAT: rd_next[CAMS-1:0] = bus.cam_hit;
            `EPR_OFS_IRQ_STAT: rd_next[2:0] = irq_stat_reg;
            `EPR_OFS_IRQ_MASK: rd_next[2:0] = irq_mask_reg;
            default: begin
                if (cam_sel) begin
                    rd_next = reg_addr[2] ? cam_hi_reg[cam_idx] : cam_lo_reg[cam_idx];
                end
            end
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_next : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Millisecond divider and cycle timer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b || mode_reg != epr_pkg::EPR_CYCLIC) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 32'h00000001) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            tick_reg     <= 1'b0;
        end
    end

    // Period register holds milliseconds minus one, so 0 is 1 ms, FFFF is 65536 ms
    assign cyc_fire = tick_reg && (ms_cnt_reg == cycle_reg);

    always_ff @(posedge clock) begin
        if (!rst_b || mode_reg != epr_pkg::EPR_CYCLIC) begin
            ms_cnt_reg <= 16'h0000;
        end else if (cyc_fire) begin
            ms_cnt_reg <= 16'h0000;
        end else if (tick_reg) begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // Sync counting
    // ----------------------------------------
    // A count of zero behaves as one so sync mode can never go silent
    assign sync_fire = (mode_reg == epr_pkg::EPR_SYNC) && sync_pulse &&
                       ((sync_cnt_reg + 16'h0001) >= sync_n_reg);

    always_ff @(posedge clock) begin
        if (!rst_b || mode_reg != epr_pkg::EPR_SYNC) begin
            sync_cnt_reg <= 16'h0000;
        end else if (sync_fire) begin
            sync_cnt_reg <= 16'h0000;
        end else if (sync_pulse) begin
            sync_cnt_reg <= sync_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    assign poll_hit = (mode_reg == epr_pkg::EPR_POLLED) && rtr_req &&
                      (rtr_id == node_id_reg);
    // Triggers that land while a frame is in flight are dropped, not queued
    assign trig     = (state_reg == epr_pkg::EPR_IDLE) &&
                      (poll_hit || cyc_fire || sync_fire);
    assign tx_done  = (state_reg == epr_pkg::EPR_SEND) && tx_ready;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            epr_pkg::EPR_IDLE: if (trig) state_next = epr_pkg::EPR_WAIT;
            epr_pkg::EPR_WAIT: if (wait_reg == 2'h1) state_next = epr_pkg::EPR_LOAD;
            epr_pkg::EPR_LOAD: state_next = epr_pkg::EPR_SEND;
            epr_pkg::EPR_SEND: if (tx_ready) state_next = epr_pkg::EPR_IDLE;
            default:           state_next = epr_pkg::EPR_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= epr_pkg::EPR_IDLE;
            wait_reg  <= 2'h0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= trig ? `EPR_PIPE_CYCLES : (wait_reg - {1'b0, wait_reg != 2'h0});
        end
    end

    // Pipeline has settled in the load state, so the value reflects every setting
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_id    <= `EPR_NODE_ID_RESET;
            tx_data  <= 32'h00000000;
        end else begin
            if (trig) begin
                tx_id <= poll_hit ? rtr_id : node_id_reg;
            end
            if (state_reg == epr_pkg::EPR_LOAD) begin
                tx_valid <= 1'b1;
                tx_data  <= {out_range, bus.pos[30:0]};
            end else if (tx_done) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Cam outputs and interrupts
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cam_out       <= '0;
            // All windows are [0,0] and pos is 0 out of reset, so every cam hits
            cam_prev_reg  <= '1;
            out_range_reg <= 1'b0;
        end else begin
            cam_out       <= bus.cam_hit;
            cam_prev_reg  <= bus.cam_hit;
            out_range_reg <= out_range;
        end
    end

    assign events[`EPR_IRQ_TX_BIT]  = tx_done;
    assign events[`EPR_IRQ_LIM_BIT] = out_range && !out_range_reg;
    assign events[`EPR_IRQ_CAM_BIT] = bus.cam_hit != cam_prev_reg;

    // A new event wins over a write-one-to-clear in the same cycle
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (reg_wr && reg_addr == `EPR_OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[2:0];
        end
        irq_stat_next = irq_stat_next | events;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (reg_wr && reg_addr == `EPR_OFS_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[2:0];
            end
            irq <= |(irq_stat_next & irq_mask_reg);
        end
    end
endmodule

// File: verification/epr_checker.sv
`include "epr_regs.svh"
module epr_checker (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        rtr_req,
    input wire logic [10:0] rtr_id,
    input wire logic        sync_pulse,
    input wire logic        tx_ready,
    input wire logic        tx_valid,
    input wire logic [10:0] tx_id,
    input wire logic [31:0] tx_data,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  mode_reg;
    logic [10:0] node_reg;
    logic        poll_m;
    // ------
    // Snooped state
    // ------
    // Copies of mode and node id, so each frame can be traced to a legal trigger
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_reg <= 2'h0;
            node_reg <= `EPR_NODE_ID_RESET;
        end else if (reg_wr && reg_addr == `EPR_OFS_CTRL) begin
            mode_reg <= reg_wdata[2:1];
        end else if (reg_wr && reg_addr == `EPR_OFS_NODE_ID) begin
            node_reg <= reg_wdata[10:0];
        end
    end
    assign poll_m = (mode_reg == 2'h0) || (mode_reg == 2'h3);
    // ------
    // Properties
    // ------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id))
        else $error("frame changed while waiting");
    a_tx_release: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("frame not released after accept");
    a_poll_answer: assert property (poll_m && $rose(tx_valid) |-> $past(rtr_req, 4))
        else $error("polled frame without request");
    a_poll_id: assert property (
        poll_m && $rose(tx_valid) |-> tx_id == $past(rtr_id, 4) && tx_id == node_reg)
        else $error("polled reply on wrong id");
    a_sync_prompt: assert property (
        mode_reg == 2'h2 && $rose(tx_valid) |-> $past(sync_pulse, 4))
        else $error("sync frame not four cycles after sync");
    a_sync_id: assert property (tx_valid && mode_reg == 2'h2 |-> tx_id == node_reg)
        else $error("sync frame on wrong id");
    a_cyclic_id: assert property (tx_valid && mode_reg == 2'h1 |-> tx_id == node_reg)
        else $error("cyclic frame on wrong id");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside read slot");
endmodule

// File: verification/epr_host.sv
module epr_host (
    input wire logic        clock,
    input wire logic        tx_valid,
    input wire logic [10:0] tx_id,
    input wire logic [31:0] tx_data,
    output logic            rtr_req,
    output logic [10:0]     rtr_id,
    output logic            sync_pulse,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int          frames, stall, wcnt, cyc, rise_last, rise_prev;
    logic [10:0] last_id;
    logic [31:0] last_data;
    logic        prev_v;
    initial begin
        rtr_req = 1'b0;
        rtr_id = 11'h7FF;
        sync_pulse = 1'b0;
        tx_ready = 1'b0;
        frames = 0;
        stall = 0;
        wcnt = 0;
        cyc = 0;
        prev_v = 1'b0;
    end
    // ------
    // Frame acceptance
    // ------
    // Ready waits stall plus one cycles, then holds until the frame is taken
    always @(posedge clock) begin
        cyc <= cyc + 1;
        prev_v <= tx_valid;
        if (tx_valid && !prev_v) begin
            rise_prev <= rise_last;
            rise_last <= cyc;
        end
        if (tx_valid && tx_ready) begin
            frames <= frames + 1;
            last_id <= tx_id;
            last_data <= tx_data;
            tx_ready <= 1'b0;
            wcnt <= 0;
        end else if (tx_valid) begin
            wcnt <= wcnt + 1;
            tx_ready <= (wcnt >= stall);
        end
    end
    // Id shows junk outside the request so a late sample is caught
    task automatic poll(input logic [10:0] id);
        @(posedge clock);
        rtr_req <= 1'b1;
        rtr_id <= id;
        @(posedge clock);
        rtr_req <= 1'b0;
        rtr_id <= ~id;
    endtask
    task automatic sync_once;
        @(posedge clock);
        sync_pulse <= 1'b1;
        @(posedge clock);
        sync_pulse <= 1'b0;
    endtask
endmodule

// File: verification/tb_encoder_position_reporting.sv
`include "epr_regs.svh"
bind epr_top epr_checker u_chk (
    .clock(clock), .rst_b(rst_b), .rtr_req(rtr_req), .rtr_id(rtr_id),
    .sync_pulse(sync_pulse), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id),
    .tx_data(tx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);
module tb_encoder_position_reporting;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic        clock, rst_b, rtr_req, sync_pulse, tx_ready, tx_valid;
    logic        reg_wr, reg_rd, irq;
    logic [10:0] rtr_id, tx_id;
    logic [31:0] raw_pos, tx_data, reg_wdata, reg_rdata, d;
    logic [7:0]  reg_addr, cam_out;
    int          mismatches, compares, cycles;
    initial clock = 1'b0;
    always #10 clock = ~clock;
    // Short tick keeps cyclic periods to tens of cycles
    epr_top #(.TICK_CYCLES(32'(TICK))) DUT (
        .clock(clock), .rst_b(rst_b), .raw_pos(raw_pos), .rtr_req(rtr_req),
        .rtr_id(rtr_id), .sync_pulse(sync_pulse), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_id(tx_id), .tx_data(tx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_out(cam_out), .irq(irq)
    );
    epr_host host (
        .clock(clock), .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data),
        .rtr_req(rtr_req), .rtr_id(rtr_id), .sync_pulse(sync_pulse), .tx_ready(tx_ready)
    );
    // ------
    // Helpers
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic frame_wait(input int n, input logic [31:0] cnt);
        int f;
        f = host.frames;
        for (int i = 0; i < n && host.frames == f; i++) @(posedge clock);
        #1 chk(32'(host.frames - f), cnt, "frames");
    endtask
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        logic [7:0]  a [6] = '{`EPR_OFS_RES, `EPR_OFS_LIM_MAX, `EPR_OFS_CYCLE,
                               `EPR_OFS_SYNC_N, `EPR_OFS_NODE_ID, 8'h3C};
        logic [31:0] e [6] = '{`EPR_RES_RESET, `EPR_LIM_MAX_RESET, 32'h00000063,
                               32'h00000001, 32'h00000181, 32'h00000000};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            chk(d, e[i], "reset value");
        end
        wr(`EPR_OFS_CAM_STAT, 32'h00000000);
        rd(`EPR_OFS_CAM_STAT, d);
        chk(d, 32'h000000FF, "cam status");
        wr(`EPR_OFS_CTRL, 32'h00000007);
        rd(`EPR_OFS_CTRL, d);
        chk(d, 32'h00000001, "mode 3 as polled");
        wr(`EPR_OFS_CTRL, 32'h00000000);
        $display("test regs done");
    endtask
    task automatic t_poll;
        raw_pos <= 32'h00038000;
        wr(`EPR_OFS_RES, 32'h00000100);
        settle();
        host.poll(11'h182);
        frame_wait(12, 32'h0);
        host.poll(`EPR_NODE_ID_RESET);
        raw_pos <= 32'h00050000;
        frame_wait(20, 32'h1);
        chk(host.last_data, 32'h00000380, "poll data");
        chk(32'(host.last_id), 32'h00000181, "poll id");
        wr(`EPR_OFS_CTRL, 32'h00000001);
        settle();
        host.poll(`EPR_NODE_ID_RESET);
        frame_wait(20, 32'h1);
        chk(host.last_data, 32'hFFFFFB00, "reversed");
        wr(`EPR_OFS_CTRL, 32'h00000000);
        settle();
        wr(`EPR_OFS_PRESET, 32'h00001234);
        settle();
        rd(`EPR_OFS_POS, d);
        chk(d, 32'h00001234, "preset");
        wr(`EPR_OFS_LIM_MAX, 32'h00001000);
        settle();
        host.poll(`EPR_NODE_ID_RESET);
        frame_wait(20, 32'h1);
        chk(host.last_data, 32'h80001234, "limit flag");
        wr(`EPR_OFS_LIM_MAX, `EPR_LIM_MAX_RESET);
        wr(`EPR_OFS_LIM_MIN, 32'h00002000);
        settle();
        rd(`EPR_OFS_POS, d);
        chk(d, 32'h80001234, "below min");
        wr(`EPR_OFS_LIM_MIN, 32'h00000000);
        $display("test poll done");
    endtask
    task automatic t_cyclic;
        wr(`EPR_OFS_CYCLE, 32'h00000001);
        wr(`EPR_OFS_CTRL, 32'h00000002);
        frame_wait(60, 32'h1);
        frame_wait(60, 32'h1);
        chk(32'(host.rise_last - host.rise_prev), 32'(2 * TICK), "period");
        wr(`EPR_OFS_CTRL, 32'h00000000);
        frame_wait(40, 32'h0);
        $display("test cyclic done");
    endtask
    task automatic t_sync;
        wr(`EPR_OFS_SYNC_N, 32'h00000003);
        wr(`EPR_OFS_CTRL, 32'h00000004);
        host.sync_once();
        host.sync_once();
        frame_wait(10, 32'h0);
        host.stall = 3;
        host.sync_once();
        frame_wait(20, 32'h1);
        chk(32'(host.last_id), 32'h00000181, "sync id");
        chk(host.last_data, 32'h00001234, "sync data");
        host.stall = 0;
        host.poll(`EPR_NODE_ID_RESET);
        host.sync_once();
        frame_wait(12, 32'h0);
        $display("test sync done");
    endtask
    task automatic t_cams;
        for (int i = 0; i < 8; i++) begin
            wr(8'(64 + 8 * i), 32'(i * 4096));
            wr(8'(68 + 8 * i), 32'(i * 4096 + 4095));
        end
        settle();
        chk({24'h000000, cam_out}, 32'h00000002, "cam pins");
        wr(`EPR_OFS_PRESET, 32'h00007FFF);
        settle();
        rd(`EPR_OFS_CAM_STAT, d);
        chk(d, 32'h00000080, "top cam");
        chk({31'h00000000, irq}, 32'h00000000, "irq masked");
        rd(`EPR_OFS_IRQ_STAT, d);
        chk(d & 32'h00000005, 32'h00000005, "events");
        wr(`EPR_OFS_IRQ_MASK, 32'h00000007);
        settle();
        chk({31'h00000000, irq}, 32'h00000001, "irq raised");
        wr(`EPR_OFS_IRQ_STAT, 32'h00000007);
        settle();
        chk({31'h00000000, irq}, 32'h00000000, "irq cleared");
        $display("test cams done");
    endtask
    // ------
    // Main sequence
    // ------
    initial begin
        rst_b = 1'b0;
        raw_pos = 32'h00000000;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_poll();
        t_cyclic();
        t_sync();
        t_cams();
        close_out();
    end
endmodule
